/* File: skzse_exec.sv */
`include "skzse_map.svh"

module skzse_exec (
  input  wire logic                    clk,          // System clock, 100 MHz.
  input  wire logic                    reset_n,      // Asynchronous reset, active low.
  input  wire logic                    instr_valid,  // Decoded instruction present.
  input  wire skzse_pkg::skzse_op_type instr_op,     // Decoded operation.
  input  wire logic [2:0]              instr_bit,    // Bit index for set-bit.
  input  wire logic [7:0]              mem_rdata,    // Addressed byte, read this cycle.
  output logic                         instr_ready,  // Block can take an instruction.
  output logic                         mem_we_q,     // Write strobe to data memory.
  output logic      [7:0]              mem_wdata_q,  // Write data to data memory.
  output logic                         acc_we_q,     // Accumulator was loaded.
  output logic      [7:0]              acc_q,        // Accumulator value.
  output logic                         skip_q,       // Discard the next fetched instruction.
  output logic                         dummy_q       // Dummy cycle in progress.
);

  skzse_pkg::skzse_state_type state_q;
  skzse_pkg::skzse_state_type state_d;
  logic [7:0] alu_result;
  logic       alu_to_mem;
  logic       alu_to_acc;
  logic       alu_skip;
  logic       take;

  // ****************************************************************
  // Arithmetic
  // ****************************************************************
  skzse_alu skzse_alu_inst (
    .op      (instr_op),
    .operand (mem_rdata),
    .bit_sel (instr_bit),
    .result  (alu_result),
    .to_mem  (alu_to_mem),
    .to_acc  (alu_to_acc),
    .skip    (alu_skip)
  );

  // Fetch is held off for the two extra cycles of a taken skip.
  assign instr_ready = (state_q == skzse_pkg::SKZSE_ST_RUN);
  assign take        = instr_valid && instr_ready;

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      skzse_pkg::SKZSE_ST_RUN: begin
        if (take && alu_skip) begin
          state_d = skzse_pkg::SKZSE_ST_DUMMY;               // see [RQ4]
        end
      end
      skzse_pkg::SKZSE_ST_DUMMY: begin
        state_d = skzse_pkg::SKZSE_ST_DROP;                  // see [RQ4]
      end
      skzse_pkg::SKZSE_ST_DROP: begin
        state_d = skzse_pkg::SKZSE_ST_RUN;
      end
      default: begin
        state_d = skzse_pkg::SKZSE_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= skzse_pkg::SKZSE_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      skip_q  <= 1'b0;
      dummy_q <= 1'b0;
    end else begin
      skip_q  <= take && alu_skip;                            // see [RQ3]
      dummy_q <= (state_d == skzse_pkg::SKZSE_ST_DUMMY);     // see [RQ4]
    end
  end

  // ****************************************************************
  // Memory write
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_we_q    <= 1'b0;
      mem_wdata_q <= `SKZSE_ZERO;
    end else begin
      mem_we_q <= take && alu_to_mem;                         // see [RQ2]
      if (take && alu_to_mem) begin
        mem_wdata_q <= alu_result;                            // see [RQ5] see [RQ6] see [RQ7]
      end
    end
  end

  // ****************************************************************
  // Accumulator
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_we_q <= 1'b0;
      acc_q    <= `SKZSE_ACC_RESET;
    end else begin
      acc_we_q <= take && alu_to_acc;
      if (take && alu_to_acc) begin
        acc_q <= alu_result;                                  // see [RQ1] see [RQ8]
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Expectations are rebuilt from the sampled inputs, so a fault in the
  // arithmetic unit cannot hide behind its own decode.
  function automatic logic acc_variant(input skzse_pkg::skzse_op_type op);
    return (op == skzse_pkg::SKZSE_OP_DEC_SKIP_ZERO_TO_ACC)
        || (op == skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_TO_ACC);
  endfunction : acc_variant

  function automatic logic skip_variant(input skzse_pkg::skzse_op_type op);
    return acc_variant(op) || (op == skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_MEM);
  endfunction : skip_variant

  function automatic logic exp_skip(input skzse_pkg::skzse_op_type op,
                                    input logic [7:0]              value);
    if (op == skzse_pkg::SKZSE_OP_DEC_SKIP_ZERO_TO_ACC) begin
      return value == 8'h01;
    end
    return skip_variant(op) && value == 8'hff;
  endfunction : exp_skip

  AST_DEC_ACC: assert property ( // see [RQ1]
    take && instr_op == skzse_pkg::SKZSE_OP_DEC_SKIP_ZERO_TO_ACC
    |=> acc_we_q && acc_q == 8'($past(mem_rdata) - 8'h01))
    else $error("Decrement result not in accumulator.");

  AST_ACC_NO_MEM: assert property ( // see [RQ2]
    take && acc_variant(instr_op) |=> !mem_we_q)
    else $error("Accumulator variant wrote memory.");

  AST_SKIP_ZERO: assert property ( // see [RQ3]
    take && skip_variant(instr_op)
    |=> skip_q == ((mem_we_q ? mem_wdata_q : acc_q) == 8'h00))
    else $error("Skip does not match zero result.");

  // A result that is not zero must let the very next instruction in.
  AST_NO_SKIP: assert property ( // see [RQ3]
    take && !exp_skip(instr_op, mem_rdata) |=> instr_ready && !skip_q && !dummy_q)
    else $error("Non-zero result held up execution.");

  // Exec, dummy and drop slot: fetch stays shut for exactly two cycles.
  AST_SKIP_THREE: assert property ( // see [RQ4]
    take && exp_skip(instr_op, mem_rdata)
    |=> !instr_ready && dummy_q ##1 !instr_ready && !dummy_q ##1 instr_ready)
    else $error("Taken skip did not last three cycles.");

  // A request that arrives while fetch is shut must leave no trace.
  AST_REFUSED: assert property ( // see [RQ4]
    !instr_ready |=> !mem_we_q && !acc_we_q && !skip_q)
    else $error("Instruction executed inside a skip window.");

  AST_DUMMY_ONE: assert property ( // see [RQ4]
    dummy_q |=> !dummy_q)
    else $error("Dummy cycle lasted more than one cycle.");

  AST_SET_BYTE: assert property ( // see [RQ5]
    take && instr_op == skzse_pkg::SKZSE_OP_SET_BYTE
    |=> mem_we_q && mem_wdata_q == 8'hff)
    else $error("Set-byte did not write all ones.");

  AST_SET_BIT: assert property ( // see [RQ6]
    take && instr_op == skzse_pkg::SKZSE_OP_SET_BIT
    |=> mem_we_q && mem_wdata_q[$past(instr_bit)]
    && ((mem_wdata_q ^ $past(mem_rdata)) & ~(8'h01 << $past(instr_bit))) == 8'h00)
    else $error("Set-bit changed the wrong bits.");

  AST_INC_MEM: assert property ( // see [RQ7]
    take && instr_op == skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_MEM
    |=> mem_we_q && mem_wdata_q == 8'($past(mem_rdata) + 8'h01) && !acc_we_q)
    else $error("Increment did not store back.");

  AST_MEM_KEEP_ACC: assert property ( // see [RQ5] see [RQ6] see [RQ7]
    take && !acc_variant(instr_op) |=> !acc_we_q && $stable(acc_q))
    else $error("Memory instruction touched the accumulator.");

  AST_INC_ACC: assert property ( // see [RQ8]
    take && instr_op == skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_TO_ACC
    |=> acc_we_q && acc_q == 8'($past(mem_rdata) + 8'h01))
    else $error("Increment result not in accumulator.");

  AST_WRAP: assert property ( // see [RQ9]
    take && instr_op == skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_MEM
    && mem_rdata == 8'hff |=> skip_q && mem_wdata_q == 8'h00)
    else $error("Increment of all ones did not wrap and skip.");

  // Main scenarios: both outcomes of a skip, a set, and a refused request.
  COV_DEC_SKIP: cover property (take && alu_skip
    && instr_op == skzse_pkg::SKZSE_OP_DEC_SKIP_ZERO_TO_ACC);
  COV_INC_NOSKIP: cover property (take && !alu_skip
    && instr_op == skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_MEM);
  COV_SET_BIT: cover property (take && instr_op == skzse_pkg::SKZSE_OP_SET_BIT);
  COV_INC_ACC_SKIP: cover property (take && alu_skip
    && instr_op == skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_TO_ACC);
  COV_REFUSED: cover property (instr_valid && !instr_ready);

endmodule : skzse_exec

/* File: skzse_map.svh */
// What this block does
// [RQ1] Decrement-to-accumulator puts the addressed byte minus one into the accumulator.
// [RQ2] Accumulator-result skip variants never write the addressed data memory byte.
// [RQ3] A zero adjusted value skips the next instruction; otherwise execution continues.
// [RQ4] A taken skip inserts a dummy cycle; the instruction lasts three cycles.
// [RQ5] Set-byte writes all ones, FFH, into the addressed byte.
// [RQ6] Set-bit forces only the selected bit to one, others unchanged.
// [RQ7] Increment-to-memory stores byte plus one back and skips on zero.
// [RQ8] Increment-to-accumulator puts byte plus one in accumulator and skips on zero.
// [RQ9] Increment and decrement wrap modulo 256 on the eight-bit byte.
`ifndef SKZSE_MAP_SVH
`define SKZSE_MAP_SVH

`define SKZSE_DATA_W     8
`define SKZSE_BIT_W      3
`define SKZSE_ALL_ONES   8'hff
`define SKZSE_ZERO       8'h00
`define SKZSE_ONE        8'h01
`define SKZSE_ACC_RESET  8'h00
`define SKZSE_SKIP_CYCLES 2'h2

`endif

/* File: skzse_pkg.sv */
package skzse_pkg;

  typedef enum logic [2:0] {
    SKZSE_OP_NONE,
    SKZSE_OP_DEC_SKIP_ZERO_TO_ACC,
    SKZSE_OP_INC_SKIP_ZERO_MEM,
    SKZSE_OP_INC_SKIP_ZERO_TO_ACC,
    SKZSE_OP_SET_BYTE,
    SKZSE_OP_SET_BIT
  } skzse_op_type;

  typedef enum logic [1:0] {
    SKZSE_ST_RUN,
    SKZSE_ST_DUMMY,
    SKZSE_ST_DROP
  } skzse_state_type;

endpackage : skzse_pkg

/* File: skzse_alu.sv */
`include "skzse_map.svh"

module skzse_alu (
  input  wire skzse_pkg::skzse_op_type op,        // Decoded operation.
  input  wire logic [7:0]              operand,   // Addressed data memory byte.
  input  wire logic [2:0]              bit_sel,   // Bit index for set-bit.
  output logic      [7:0]              result,    // Adjusted value.
  output logic                         to_mem,    // Result goes back to memory.
  output logic                         to_acc,    // Result goes to the accumulator.
  output logic                         skip       // Skip the next instruction.
);

  // ****************************************************************
  // Shared arithmetic
  // ****************************************************************
  // Eight-bit arithmetic wraps by itself, which is what the zero test relies on.
  function automatic logic [7:0] step_byte(input logic [7:0] value, input logic up);
    return up ? value + `SKZSE_ONE : value - `SKZSE_ONE;
  endfunction : step_byte

  function automatic logic is_zero(input logic [7:0] value);
    return value == `SKZSE_ZERO;
  endfunction : is_zero

  // ****************************************************************
  // Result selection
  // ****************************************************************
  always_comb begin
    result = operand;
    to_mem = 1'b0;
    to_acc = 1'b0;
    skip   = 1'b0;
    case (op)
      skzse_pkg::SKZSE_OP_DEC_SKIP_ZERO_TO_ACC: begin
        result = step_byte(operand, 1'b0);                   // see [RQ1] see [RQ9]
        to_acc = 1'b1;                                       // see [RQ2]
        skip   = is_zero(result);                            // see [RQ3]
      end
      skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_MEM: begin
        result = step_byte(operand, 1'b1);                   // see [RQ7] see [RQ9]
        to_mem = 1'b1;
        skip   = is_zero(result);                            // see [RQ3]
      end
      skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_TO_ACC: begin
        result = step_byte(operand, 1'b1);                   // see [RQ8] see [RQ9]
        to_acc = 1'b1;                                       // see [RQ2]
        skip   = is_zero(result);                            // see [RQ3]
      end
      skzse_pkg::SKZSE_OP_SET_BYTE: begin
        result = `SKZSE_ALL_ONES;                            // see [RQ5]
        to_mem = 1'b1;
      end
      skzse_pkg::SKZSE_OP_SET_BIT: begin
        result = operand | (`SKZSE_ONE << bit_sel);          // see [RQ6]
        to_mem = 1'b1;
      end
      default: begin
        result = operand;
      end
    endcase
  end

endmodule : skzse_alu

/* File: skip_and_set_instr_exec_tb.sv */
module skip_and_set_instr_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    clk;
  logic                    reset_n;
  logic                    instr_valid;
  skzse_pkg::skzse_op_type instr_op;
  logic [2:0]              instr_bit;
  logic [7:0]              mem_rdata;
  logic                    instr_ready;
  logic                    mem_we_q;
  logic [7:0]              mem_wdata_q;
  logic                    acc_we_q;
  logic [7:0]              acc_q;
  logic                    skip_q;
  logic                    dummy_q;
  logic [7:0]              exp_acc;
  int                      fails;
  int                      n_checks;
  int                      cycles;

  skzse_exec skzse_exec_inst (
    .clk, .reset_n, .instr_valid, .instr_op, .instr_bit, .mem_rdata, .instr_ready,
    .mem_we_q, .mem_wdata_q, .acc_we_q, .acc_q, .skip_q, .dummy_q
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One instruction, then the whole skip window when a skip is expected.
  task automatic run(input skzse_pkg::skzse_op_type op, input logic [2:0] b,
                     input logic [7:0] rd, input logic mwe, input logic [7:0] wd,
                     input logic awe, input logic [7:0] av, input logic sk);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op    <= op;
    instr_bit   <= b;
    mem_rdata   <= rd;
    @(posedge clk);
    instr_valid <= 1'b0;
    mem_rdata   <= ~rd;
    @(negedge clk);
    if (awe) begin
      exp_acc = av;
    end
    chk({7'h00, mem_we_q}, {7'h00, mwe}, "memory write strobe");
    if (mwe) begin
      chk(mem_wdata_q, wd, "memory write data");
    end
    chk({7'h00, acc_we_q}, {7'h00, awe}, "accumulator strobe");
    chk(acc_q, exp_acc, "accumulator value");
    chk({7'h00, skip_q}, {7'h00, sk}, "skip pulse");
    chk({7'h00, dummy_q}, {7'h00, sk}, "dummy cycle");
    chk({7'h00, instr_ready}, {7'h00, ~sk}, "ready after take");
    if (sk) begin
      @(negedge clk);
      chk({7'h00, instr_ready}, 8'h00, "ready in drop slot");
      chk({7'h00, dummy_q}, 8'h00, "dummy past its cycle");
      @(negedge clk);
      chk({7'h00, instr_ready}, 8'h01, "ready after three cycles");
    end
  endtask : run

  task automatic sc_dec_acc;
    run(skzse_pkg::SKZSE_OP_DEC_SKIP_ZERO_TO_ACC, 3'h0, 8'h05,
        1'b0, 8'h00, 1'b1, 8'h04, 1'b0);
    run(skzse_pkg::SKZSE_OP_DEC_SKIP_ZERO_TO_ACC, 3'h0, 8'h01,
        1'b0, 8'h00, 1'b1, 8'h00, 1'b1);
    run(skzse_pkg::SKZSE_OP_DEC_SKIP_ZERO_TO_ACC, 3'h0, 8'h00,
        1'b0, 8'h00, 1'b1, 8'hff, 1'b0);
  endtask : sc_dec_acc

  task automatic sc_inc_mem;
    run(skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_MEM, 3'h0, 8'hff,
        1'b1, 8'h00, 1'b0, 8'h00, 1'b1);
    run(skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_MEM, 3'h0, 8'h7f,
        1'b1, 8'h80, 1'b0, 8'h00, 1'b0);
  endtask : sc_inc_mem

  task automatic sc_inc_acc;
    run(skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_TO_ACC, 3'h0, 8'hff,
        1'b0, 8'h00, 1'b1, 8'h00, 1'b1);
    run(skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_TO_ACC, 3'h0, 8'hfe,
        1'b0, 8'h00, 1'b1, 8'hff, 1'b0);
  endtask : sc_inc_acc

  task automatic sc_set;
    run(skzse_pkg::SKZSE_OP_SET_BYTE, 3'h0, 8'h5a,
        1'b1, 8'hff, 1'b0, 8'h00, 1'b0);
    for (int i = 0; i < 8; i++) begin
      run(skzse_pkg::SKZSE_OP_SET_BIT, 3'(i), 8'h5a,
          1'b1, 8'h5a | (8'h01 << i), 1'b0, 8'h00, 1'b0);
    end
  endtask : sc_set

  // A request held through a taken skip must wait until fetch reopens.
  task automatic sc_refused;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op    <= skzse_pkg::SKZSE_OP_INC_SKIP_ZERO_MEM;
    mem_rdata   <= 8'hff;
    @(posedge clk);
    instr_op    <= skzse_pkg::SKZSE_OP_SET_BYTE;
    mem_rdata   <= 8'h00;
    @(negedge clk);
    chk({7'h00, skip_q}, 8'h01, "skip before refusal");
    @(negedge clk);
    chk({7'h00, mem_we_q}, 8'h00, "write in dummy slot");
    @(negedge clk);
    chk({7'h00, mem_we_q}, 8'h00, "write in drop slot");
    chk({7'h00, instr_ready}, 8'h01, "ready after refusal window");
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    chk({7'h00, mem_we_q}, 8'h01, "held request taken");
    chk(mem_wdata_q, 8'hff, "held request data");
  endtask : sc_refused

  // A hang is cut short well beyond the fifty or so cycles the scenarios need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    reset_n     = 1'b0;
    instr_valid = 1'b0;
    instr_op    = skzse_pkg::SKZSE_OP_NONE;
    instr_bit   = 3'h0;
    mem_rdata   = 8'h00;
    exp_acc     = 8'h00;
    fails       = 0;
    n_checks    = 0;
    cycles      = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk(acc_q, 8'h00, "accumulator after reset");
    chk({7'h00, instr_ready}, 8'h01, "ready after reset");
    sc_dec_acc();
    sc_inc_mem();
    sc_inc_acc();
    sc_set();
    sc_refused();
    close_out();
  end
endmodule : skip_and_set_instr_exec_tb
